/* lcd_timing_pkg.sv */
// Purpose: Shared constants and types for the passive panel timing block
// Assumes: Config fields stay stable while a frame is running
// Notes:   Pixel words are one 4-bit nibble each
package lcd_timing_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int unsigned NIBBLE_W   = 4;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned PIX_CNT_W  = 10;
    localparam int unsigned LINE_CNT_W = 10;
    localparam int unsigned DF_CNT_W   = 8;

    // ****************************************
    // Link timing
    // ****************************************
    // Link clocks per panel shift clock period
    localparam int unsigned SCLK_DIV       = 4;
    localparam int unsigned PHASE_W        = 2;
    localparam logic [1:0]  PHASE_RISE     = 2'h1;
    localparam logic [1:0]  PHASE_FALL     = 2'h3;
    localparam logic [1:0]  PHASE_RESET    = 2'h0;
    localparam logic [3:0]  NIBBLE_IDLE    = 4'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [PIX_CNT_W-1:0]  shifts_per_line;
        logic [LINE_CNT_W-1:0] lines_per_frame;
        logic                  ac_by_lines;
        logic [DF_CNT_W-1:0]   ac_line_count;
        logic                  display_on;
    } lcd_cfg_type;

    typedef enum logic [2:0] {
        ST_SHIFT = 3'b001,
        ST_LINE  = 3'b010,
        ST_FRAME = 3'b100
    } lcd_state_type;

endpackage : lcd_timing_pkg

/* lcd_panel_timing_interface.sv */
// Purpose: Pixel FIFO and passive panel timing generator
// Assumes: cfg_i is driven from the link clock domain
// Notes:   Data underrun shifts idle nibbles; timing never stalls
//
// Summary of operation
// R1 - Frame sync only after all lines sent
// R2 - Panel homes its pointers on frame sync
// R3 - Line sync after a full line shifted
// R4 - Panel latches its line on line sync
// R5 - AC polarity toggles per frame or lines
// R6 - Panel reverses drive on polarity change
// R7 - Pixel data changes on shift clock rise
// R8 - Panel samples data on shift clock fall
// R9 - Pixel data is a 4-bit bus
// R10 - External logic widens nibbles to 8 bits
// R11 - Display-on enable output to the panel
// R12 - Line length and frame height programmable
`timescale 1ns/1ps

module pixel_fifo #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Drain side
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    // Full level needs the extra count bit, or it wraps to zero
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             ready_q;
    wire              push = in_valid_i & ready_q;
    wire              pop  = out_valid_o & out_ready_i;

    assign count_d     = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready_o  = ready_q;
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            ready_q  <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            count_q  <= count_d;
            ready_q  <= (count_d != FULL_COUNT);
        end
    end
endmodule : pixel_fifo

module lcd_panel_timing_interface
    import lcd_timing_pkg::*;
(
    // System clock and reset
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    // Panel link clock
    input  wire logic                link_clk_i,
    // Pixel stream in
    input  wire logic [NIBBLE_W-1:0] pixel_data_i,
    input  wire logic                pixel_valid_i,
    output logic                     pixel_ready_o,
    // Configuration, link domain
    input  wire lcd_cfg_type         cfg_i,
    // Panel pins
    output logic                     panel_shift_clock_o,
    output logic [NIBBLE_W-1:0]      pixel_data_nibble_o,
    output logic                     line_sync_o,
    output logic                     frame_sync_o,
    output logic                     ac_polarity_toggle_o,
    output logic                     panel_display_enable_o
);
    // ****************************************
    // System side: FIFO and word handshake
    // ****************************************
    logic [NIBBLE_W-1:0] fifo_data;
    logic                fifo_valid;
    logic [NIBBLE_W-1:0] hold_q;
    logic                req_q;
    logic                ack_s1_q;
    logic                ack_s2_q;
    logic                ack_q;
    wire                 pending = req_q ^ ack_s2_q;
    wire                 launch  = fifo_valid & ~pending;

    pixel_fifo #(
        .WIDTH (NIBBLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_data_i   (pixel_data_i),
        .in_valid_i  (pixel_valid_i),
        .in_ready_o  (pixel_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (launch)
    );

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            req_q    <= 1'b0;
            hold_q   <= NIBBLE_IDLE;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            if (launch) begin
                hold_q <= fifo_data;
                req_q  <= ~req_q;
            end
        end
    end

    // ****************************************
    // Link side: reset, word capture
    // ****************************************
    logic                rst_s1_q;
    logic                link_rstn_q;
    logic                req_s1_q;
    logic                req_s2_q;
    logic [NIBBLE_W-1:0] word_q;
    logic                avail_q;
    lcd_cfg_type         cfg_q;
    wire                 capture = (req_s2_q ^ ack_q) & ~avail_q;

    always_ff @(posedge link_clk_i) begin
        rst_s1_q    <= resetn_i;
        link_rstn_q <= rst_s1_q;
    end

    // ****************************************
    // Link side: timing state
    // ****************************************
    lcd_state_type         state_q;
    lcd_state_type         state_d;
    logic [PHASE_W-1:0]    phase_q;
    logic [PIX_CNT_W-1:0]  pix_cnt_q;
    logic [LINE_CNT_W-1:0] line_cnt_q;
    logic [DF_CNT_W-1:0]   df_cnt_q;

    wire at_rise    = (phase_q == PHASE_RISE);
    wire at_fall    = (phase_q == PHASE_FALL);
    wire running    = cfg_q.display_on;
    wire shifting   = running & (state_q == ST_SHIFT);
    wire take_pix   = shifting & at_rise;
    wire last_pix   = (pix_cnt_q == cfg_q.shifts_per_line - PIX_CNT_W'(1));
    wire last_line  = (line_cnt_q == cfg_q.lines_per_frame - LINE_CNT_W'(1));
    wire last_df    = (df_cnt_q == cfg_q.ac_line_count - DF_CNT_W'(1));
    wire line_end   = shifting & at_fall & last_pix;
    wire line_done  = (state_q == ST_LINE) & at_fall;
    wire frame_go   = line_done & last_line;
    wire frame_done = (state_q == ST_FRAME) & at_fall;
    wire ac_flip    = cfg_q.ac_by_lines ? (line_end & last_df) : frame_go;
    wire consume    = take_pix & avail_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_SHIFT: begin
                if (line_end) state_d = ST_LINE;
            end
            ST_LINE: begin
                if (line_done) state_d = last_line ? ST_FRAME : ST_SHIFT;
            end
            ST_FRAME: begin
                if (frame_done) state_d = ST_SHIFT;
            end
        endcase
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rstn_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q    <= 1'b0;
            avail_q  <= 1'b0;
            word_q   <= NIBBLE_IDLE;
            cfg_q    <= '0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            cfg_q    <= cfg_i;
            if (capture) begin
                word_q  <= hold_q;
                avail_q <= 1'b1;
                ack_q   <= ~ack_q;
            end else if (consume) begin
                avail_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!link_rstn_q || !running) begin
            state_q    <= ST_SHIFT;
            phase_q    <= PHASE_RESET;
            pix_cnt_q  <= '0;
            line_cnt_q <= '0;
            df_cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_q + PHASE_W'(1);
            if (shifting && at_fall) begin
                pix_cnt_q <= last_pix ? '0 : pix_cnt_q + PIX_CNT_W'(1); // R12
            end
            if (line_done) begin
                line_cnt_q <= last_line ? '0 : line_cnt_q + LINE_CNT_W'(1); // R12
            end
            if (line_end) begin
                df_cnt_q <= last_df ? '0 : df_cnt_q + DF_CNT_W'(1);
            end
        end
    end

    // ****************************************
    // Link side: panel pins
    // ****************************************
    always_ff @(posedge link_clk_i) begin
        if (!link_rstn_q) begin
            panel_shift_clock_o    <= 1'b0;
            pixel_data_nibble_o    <= NIBBLE_IDLE;
            line_sync_o            <= 1'b0;
            frame_sync_o           <= 1'b0;
            ac_polarity_toggle_o   <= 1'b0;
            panel_display_enable_o <= 1'b0;
        end else begin
            panel_display_enable_o <= running; // R11
            if (take_pix) begin
                panel_shift_clock_o <= 1'b1;
                pixel_data_nibble_o <= avail_q ? word_q : NIBBLE_IDLE; // R7 R9
            end else if (at_fall || !running) begin
                panel_shift_clock_o <= 1'b0;
            end
            if (line_end) line_sync_o <= 1'b1; // R3
            else if (line_done || !running) line_sync_o <= 1'b0;
            if (frame_go) frame_sync_o <= 1'b1; // R1
            else if (frame_done || !running) frame_sync_o <= 1'b0;
            if (running && ac_flip) ac_polarity_toggle_o <= ~ac_polarity_toggle_o; // R5
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_last_pixel;
        shifting && at_fall && last_pix;
    endsequence

    sequence s_line_pulse;
        line_sync_o [*4];
    endsequence

    property p_frame_after_lines;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        $rose(frame_sync_o) |-> $past(line_sync_o) && $past(last_line);
    endproperty
    a_frame_after_lines: assert property (p_frame_after_lines) // R1
        else $error("Frame sync without a finished last line");

    property p_line_after_pixels;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        s_last_pixel |=> s_line_pulse;
    endproperty
    a_line_after_pixels: assert property (p_line_after_pixels) // R3
        else $error("Line sync missing after last pixel");

    property p_line_count;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        $rose(line_sync_o) |-> $past(pix_cnt_q) == cfg_q.shifts_per_line - PIX_CNT_W'(1);
    endproperty
    a_line_count: assert property (p_line_count) // R12
        else $error("Line sync at wrong shift count");

    property p_ac_per_frame;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        $rose(frame_sync_o) && !$past(cfg_q.ac_by_lines) |-> $changed(ac_polarity_toggle_o);
    endproperty
    a_ac_per_frame: assert property (p_ac_per_frame) // R5
        else $error("AC polarity did not toggle on frame");

    property p_ac_cause;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        $changed(ac_polarity_toggle_o) |-> $rose(frame_sync_o) || $rose(line_sync_o);
    endproperty
    a_ac_cause: assert property (p_ac_cause) // R5
        else $error("AC polarity toggled without a sync");

    property p_data_on_rise;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        $changed(pixel_data_nibble_o) |-> $rose(panel_shift_clock_o);
    endproperty
    a_data_on_rise: assert property (p_data_on_rise) // R7
        else $error("Pixel data changed away from shift clock rise");

    property p_data_word;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        take_pix && avail_q |=> pixel_data_nibble_o == $past(word_q) ##3 !panel_shift_clock_o;
    endproperty
    a_data_word: assert property (p_data_word) // R9
        else $error("Pixel nibble does not match the fetched word");

    property p_enable_gates_clock;
        @(posedge link_clk_i) disable iff (!link_rstn_q)
        !panel_display_enable_o && !$past(running) |-> !panel_shift_clock_o;
    endproperty
    a_enable_gates_clock: assert property (p_enable_gates_clock) // R11
        else $error("Shift clock runs while display is off");

endmodule : lcd_panel_timing_interface

/* lcd_panel_model.sv */
// Purpose: Behavioural passive panel for the timing bench
// Assumes: Pins come straight from the timing block
// Notes:   The bench reads the counters by hierarchy
`timescale 1ns/1ps

module lcd_panel_model
    import lcd_timing_pkg::*;
(
    // Panel pins
    input wire logic                sclk_i,
    input wire logic [NIBBLE_W-1:0] data_i,
    input wire logic                line_i,
    input wire logic                frame_i,
    input wire logic                ac_i
);
    logic [NIBBLE_W-1:0] log_q [0:63];
    logic [NIBBLE_W-1:0] rise_val;
    // External pairing register, two nibbles to a byte
    logic [7:0]          byte_q = '0;
    int                  n_log = 0;
    int                  px = 0;
    int                  px_line = 0;
    int                  rows = 0;
    int                  rows_frame = 0;
    int                  lines = 0;
    int                  lines_ac = 0;
    int                  bad = 0;

    always @(posedge sclk_i) begin
        #1 rise_val = data_i;
    end
    // Data must not move while the clock is high
    always @(negedge sclk_i) begin
        log_q[n_log % 64] = data_i;
        byte_q = {byte_q[3:0], data_i};
        n_log++;
        px++;
        if (data_i !== rise_val) bad++;
    end
    always @(posedge line_i) begin
        px_line = px;
        px = 0;
        rows++;
        lines++;
    end
    always @(posedge frame_i) begin
        rows_frame = rows;
        rows = 0;
    end
    // Settle after a line sync on the same edge
    always @(ac_i) begin
        #1 lines_ac = lines;
        lines = 0;
    end
endmodule : lcd_panel_model

/* lcd_panel_timing_interface_tb.sv */
// Purpose: Self-checking bench for the panel timing block
// Assumes: Panel model sits on the panel pins
// Notes:   Reset held long enough for the link domain
`timescale 1ns/1ps

module lcd_panel_timing_interface_tb;
    import lcd_timing_pkg::*;
    logic                clk_i = 1'b0;
    logic                link_clk_i = 1'b0;
    logic                resetn_i = 1'b0;
    logic                pixel_valid_i = 1'b0;
    logic [NIBBLE_W-1:0] pixel_data_i = '0;
    lcd_cfg_type         cfg_i = '0;
    logic                pixel_ready_o;
    logic                sclk;
    logic                line_s;
    logic                frame_s;
    logic                ac;
    logic                den;
    logic [NIBBLE_W-1:0] nib;
    int                  error_cnt = 0;
    int                  num_checks = 0;
    int                  cyc = 0;

    always #5 clk_i = ~clk_i;
    initial begin
        #3;
        forever #16 link_clk_i = ~link_clk_i;
    end

    lcd_panel_timing_interface dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
        .pixel_data_i(pixel_data_i), .pixel_valid_i(pixel_valid_i),
        .pixel_ready_o(pixel_ready_o), .cfg_i(cfg_i),
        .panel_shift_clock_o(sclk), .pixel_data_nibble_o(nib),
        .line_sync_o(line_s), .frame_sync_o(frame_s),
        .ac_polarity_toggle_o(ac), .panel_display_enable_o(den));

    lcd_panel_model pm_u (
        .sclk_i(sclk), .data_i(nib), .line_i(line_s), .frame_i(frame_s), .ac_i(ac));

    // ****
    // Tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic set_cfg(input lcd_cfg_type c);
        @(negedge link_clk_i);
        cfg_i = c;
    endtask : set_cfg

    task automatic wait_frame();
        int k;
        for (k = 0; k < 3000 && frame_s !== 1'b0; k++) @(negedge clk_i);
        for (k = 0; k < 3000 && frame_s !== 1'b1; k++) @(negedge clk_i);
        check(frame_s, 1);
    endtask : wait_frame

    task automatic wait_ac();
        logic a;
        int   k;
        a = ac;
        for (k = 0; k < 3000 && ac === a; k++) @(negedge clk_i);
        check(k < 3000, 1);
    endtask : wait_ac

    // Fill until refused, panel dark
    task automatic t_fill();
        int n;
        n = 0;
        @(negedge clk_i);
        pixel_valid_i = 1'b1;
        while (pixel_ready_o === 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
            pixel_data_i = n[3:0];
        end
        pixel_valid_i = 1'b0;
        check(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, 1);
        check(pm_u.n_log, 0);
        check(den, 0);
    endtask : t_fill

    // Two frames of two lines of three pixels
    task automatic t_frame();
        logic a1;
        int   i;
        set_cfg('{10'd3, 10'd2, 1'b0, 8'd1, 1'b1});
        wait_frame();
        a1 = ac;
        check(pm_u.rows_frame, 2);
        check(pm_u.px_line, 3);
        check(den, 1);
        wait_frame();
        check(ac, !a1);
        check(pm_u.n_log, 12);
        for (i = 0; i < 12; i++) check(pm_u.log_q[i], i & 15);
        check(pm_u.byte_q, 8'hab);
    endtask : t_frame

    // Polarity every third line, four lines a frame
    task automatic t_lines();
        set_cfg('{10'd2, 10'd4, 1'b1, 8'd3, 1'b1});
        repeat (3) wait_ac();
        // Let the panel model settle its count
        @(negedge clk_i);
        check(pm_u.lines_ac, 3);
        check(pm_u.rows_frame, 4);
        repeat (4) wait_frame();
        check(pm_u.log_q[(pm_u.n_log - 1) % 64], 0);
        check(pm_u.bad, 0);
    endtask : t_lines

    task automatic t_off();
        int n;
        set_cfg('{10'd2, 10'd4, 1'b1, 8'd3, 1'b0});
        repeat (8) @(negedge link_clk_i);
        n = pm_u.n_log;
        repeat (20) @(negedge link_clk_i);
        check({den, sclk, line_s, frame_s}, 0);
        check(pm_u.n_log, n);
    endtask : t_off

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        check({pixel_ready_o, den}, 0);
        resetn_i = 1'b1;
        repeat (4) @(negedge link_clk_i);
        t_fill();
        t_frame();
        t_lines();
        t_off();
        print_verdict();
    end
endmodule : lcd_panel_timing_interface_tb
